// ---- design/io_port_block.sv ----
// Purpose: Four bidirectional eight-bit ports with port A falling-edge wake-up
// Assumes: Pins synchronous to sys_clk; straps stable from power-up
// Notes:   Pin enables are active low; pull-high requests go to the pads
`timescale 1ns/1ps
module io_port_block #(
	parameter int WIDTH = io_port_pkg::PORT_W
) (
	input  wire logic             sys_clk,
	input  wire logic             nrst,
	// Software access
	input  wire logic             acc_valid,
	input  wire logic [1:0]       acc_port,
	input  wire logic             acc_target,
	input  wire logic [1:0]       acc_op,
	input  wire logic [2:0]       acc_bit,
	input  wire logic [WIDTH-1:0] acc_wdata,
	input  wire logic             rd_valid,
	input  wire logic [1:0]       rd_port,
	input  wire logic             rd_target,
	output logic      [WIDTH-1:0] rd_data,
	output logic                  rd_done,
	output logic                  acc_done,
	// Power-down
	input  wire logic             halt_req,
	input  wire logic [WIDTH-1:0] wake_enable,
	output logic                  halted,
	output logic                  wake_pulse,
	// Straps and shared functions
	input  wire logic             opt_divider_en,
	input  wire logic             opt_pwm0_en,
	input  wire logic             opt_pwm1_en,
	input  wire logic [WIDTH-1:0] opt_pull_high_a,
	input  wire logic [WIDTH-1:0] opt_pull_high_b,
	input  wire logic [WIDTH-1:0] opt_pull_high_c,
	input  wire logic [WIDTH-1:0] opt_pull_high_d,
	input  wire logic             freq_divider_output,
	input  wire logic             pwm0_out,
	input  wire logic             pwm1_out,
	input  wire logic [3:0]       analog_select,
	// Pads
	input  wire logic [WIDTH-1:0] pin_a_in,
	input  wire logic [WIDTH-1:0] pin_b_in,
	input  wire logic [WIDTH-1:0] pin_c_in,
	input  wire logic [WIDTH-1:0] pin_d_in,
	output logic      [WIDTH-1:0] pin_a_out,
	output logic      [WIDTH-1:0] pin_b_out,
	output logic      [WIDTH-1:0] pin_c_out,
	output logic      [WIDTH-1:0] pin_d_out,
	output logic      [WIDTH-1:0] pin_a_oe_n,
	output logic      [WIDTH-1:0] pin_b_oe_n,
	output logic      [WIDTH-1:0] pin_c_oe_n,
	output logic      [WIDTH-1:0] pin_d_oe_n,
	output logic      [WIDTH-1:0] pull_a,
	output logic      [WIDTH-1:0] pull_b,
	output logic      [WIDTH-1:0] pull_c,
	output logic      [WIDTH-1:0] pull_d
);
	localparam int NP    = io_port_pkg::NUM_PORTS;
	localparam int DEPTH = 2 * NP;

	////////////////////////////////////////////////////////////////////////////////
	// State

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_RMW
	} seq_t;

	typedef struct packed {
		seq_t                   seq;
		logic [1:0]             port;
		logic                   target;
		logic [1:0]             op;
		logic [2:0]             bitn;
		logic [WIDTH-1:0]       wdata;
		logic                   acc_done;
		logic                   rd_pend;
		logic                   rd_sel_data;
		logic [1:0]             rd_port;
		logic [WIDTH-1:0]       rd_pins;
		logic [WIDTH-1:0]       rd_data;
		logic                   rd_done;
		logic                   halted;
		logic                   wake_pulse;
		logic [WIDTH-1:0]       wake_prev;
		logic                   opt_div;
		logic                   opt_pwm0;
		logic                   opt_pwm1;
		logic                   opt_taken;
		logic [NP-1:0][WIDTH-1:0] pout;
		logic [NP-1:0][WIDTH-1:0] poe_n;
		logic [NP-1:0][WIDTH-1:0] pull;
	} blk_state_t;

	blk_state_t state;
	blk_state_t next_state;

	logic                   bank_we;
	logic [2:0]             bank_waddr;
	logic [WIDTH-1:0]       bank_wdata;
	logic [2:0]             bank_raddr;
	logic [WIDTH-1:0]       bank_rdata;
	logic [DEPTH*WIDTH-1:0] bank_all;

	function automatic logic [2:0] slot(input logic [1:0] port, input logic target);
		slot = {target, port};
	endfunction

	function automatic logic [WIDTH-1:0] pick_pins(input logic [1:0] port,
			input logic [WIDTH-1:0] a, input logic [WIDTH-1:0] b,
			input logic [WIDTH-1:0] c, input logic [WIDTH-1:0] d);
		case (port)
			io_port_pkg::PORT_A: pick_pins = a;
			io_port_pkg::PORT_B: pick_pins = b;
			io_port_pkg::PORT_C: pick_pins = c;
			default:             pick_pins = d;
		endcase
	endfunction

	// Merge latch and pins per direction: input bits show the pin
	function automatic logic [WIDTH-1:0] merge(input logic [WIDTH-1:0] latch,
			input logic [WIDTH-1:0] dir, input logic [WIDTH-1:0] pins);
		merge = (dir & pins) | (~dir & latch);
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Latch bank

	port_bank #(
		.WIDTH (WIDTH),
		.DEPTH (DEPTH)
	) u_bank (
		.sys_clk  (sys_clk),
		.nrst     (nrst),
		.wr_en    (bank_we),
		.wr_addr  (bank_waddr),
		.wr_data  (bank_wdata),
		.rd_addr  (bank_raddr),
		.rd_data  (bank_rdata),
		.all_data (bank_all)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Next state

	always_comb begin
		logic [WIDTH-1:0]          pins;
		logic [WIDTH-1:0]          dir_now;
		logic [WIDTH-1:0]          byte_now;
		logic [WIDTH-1:0]          falls;
		logic [NP-1:0][WIDTH-1:0]  lat;
		logic [NP-1:0][WIDTH-1:0]  dir;
		logic [NP-1:0][WIDTH-1:0]  opt_pull;
		pins       = '0;
		dir_now    = '0;
		byte_now   = '0;
		falls      = '0;
		lat        = '0;
		dir        = '0;
		opt_pull   = {opt_pull_high_d, opt_pull_high_c, opt_pull_high_b, opt_pull_high_a};
		next_state = state;
		bank_we    = 1'b0;
		bank_waddr = '0;
		bank_wdata = '0;
		bank_raddr = slot(state.port, state.target);
		for (int p = 0; p < NP; p++) begin
			lat[p] = bank_all[p*WIDTH +: WIDTH];
			dir[p] = bank_all[(p+NP)*WIDTH +: WIDTH];
		end
		next_state.acc_done   = 1'b0;
		next_state.rd_done    = 1'b0;
		next_state.wake_pulse = 1'b0;

		// Straps latched once after reset release so later changes are ignored
		if (!state.opt_taken) begin
			next_state.opt_div   = opt_divider_en;
			next_state.opt_pwm0  = opt_pwm0_en;
			next_state.opt_pwm1  = opt_pwm1_en;
			next_state.opt_taken = 1'b1;
		end

		// Register reads sample the pins now, not a stored copy
		if (rd_valid && state.seq == ST_IDLE) begin
			next_state.rd_pend     = 1'b1;
			next_state.rd_port     = rd_port;
			next_state.rd_sel_data = (rd_target == io_port_pkg::SEL_DATA);
			next_state.rd_pins     = pick_pins(rd_port, pin_a_in, pin_b_in,
				pin_c_in, pin_d_in);
			bank_raddr             = slot(rd_port, rd_target);
		end
		if (state.rd_pend) begin
			next_state.rd_pend = 1'b0;
			next_state.rd_done = 1'b1;
			next_state.rd_data = state.rd_sel_data ?
				merge(bank_rdata, dir[state.rd_port], state.rd_pins) : bank_rdata;
		end

		case (state.seq)
			ST_IDLE: begin
				if (acc_valid && acc_op != io_port_pkg::OP_NONE) begin
					next_state.port   = acc_port;
					next_state.target = acc_target;
					next_state.op     = acc_op;
					next_state.bitn   = acc_bit;
					next_state.wdata  = acc_wdata;
					if (acc_op == io_port_pkg::OP_WRITE_BYTE) begin
						bank_we             = 1'b1;
						bank_waddr          = slot(acc_port, acc_target);
						bank_wdata          = acc_wdata;
						next_state.acc_done = 1'b1;
					end else begin
						next_state.seq = ST_RMW;
					end
				end
			end
			ST_RMW: begin
				// Whole-port read: data target reads live pins on input bits
				pins     = pick_pins(state.port, pin_a_in, pin_b_in, pin_c_in, pin_d_in);
				dir_now  = dir[state.port];
				byte_now = (state.target == io_port_pkg::SEL_DATA) ?
					merge(lat[state.port], dir_now, pins) : dir_now;
				byte_now[state.bitn] = (state.op == io_port_pkg::OP_SET_BIT);
				bank_we             = 1'b1;
				bank_waddr          = slot(state.port, state.target);
				bank_wdata          = byte_now;
				next_state.acc_done = 1'b1;
				next_state.seq      = ST_IDLE;
			end
			default: next_state.seq = ST_IDLE;
		endcase

		// Pad drive
		for (int p = 0; p < NP; p++) begin
			next_state.pout[p]  = lat[p];
			next_state.poe_n[p] = dir[p];
			next_state.pull[p]  = opt_pull[p] & dir[p];
		end
		if (state.opt_div && !dir[io_port_pkg::PORT_A][io_port_pkg::DIV_BIT]) begin
			next_state.pout[io_port_pkg::PORT_A][io_port_pkg::DIV_BIT] = freq_divider_output;
		end
		if (state.opt_pwm0 && !dir[io_port_pkg::PORT_D][io_port_pkg::PWM0_BIT]) begin
			next_state.pout[io_port_pkg::PORT_D][io_port_pkg::PWM0_BIT] = pwm0_out;
		end
		if (state.opt_pwm1 && !dir[io_port_pkg::PORT_D][io_port_pkg::PWM1_BIT]) begin
			next_state.pout[io_port_pkg::PORT_D][io_port_pkg::PWM1_BIT] = pwm1_out;
		end
		for (int i = 0; i < io_port_pkg::ANALOG_W; i++) begin
			if (analog_select[i]) begin
				next_state.pull[io_port_pkg::PORT_B][io_port_pkg::ANALOG_LSB + i] = 1'b0;
			end
		end

		// Wake-up: per-pin falling edge while halted; wake wins over a new halt
		falls                = state.wake_prev & ~pin_a_in & wake_enable;
		next_state.wake_prev = pin_a_in;
		if (state.halted && |falls) begin
			next_state.halted     = 1'b0;
			next_state.wake_pulse = 1'b1;
		end else if (halt_req) begin
			next_state.halted = 1'b1;
		end

		if (!nrst) begin
			next_state.seq         = ST_IDLE;
			next_state.port        = '0;
			next_state.target      = 1'b0;
			next_state.op          = '0;
			next_state.bitn        = '0;
			next_state.wdata       = '0;
			next_state.acc_done    = 1'b0;
			next_state.rd_pend     = 1'b0;
			next_state.rd_sel_data = 1'b0;
			next_state.rd_port     = '0;
			next_state.rd_pins     = '0;
			next_state.rd_data     = '0;
			next_state.rd_done     = 1'b0;
			next_state.halted      = 1'b0;
			next_state.wake_pulse  = 1'b0;
			next_state.wake_prev   = '1;
			next_state.opt_div     = 1'b0;
			next_state.opt_pwm0    = 1'b0;
			next_state.opt_pwm1    = 1'b0;
			next_state.opt_taken   = 1'b0;
			next_state.pout        = {NP{io_port_pkg::RESET_BYTE}};
			next_state.poe_n       = {NP{io_port_pkg::RESET_BYTE}};
			next_state.pull        = '0;
			bank_we                = 1'b0;
		end
	end

	always_ff @(posedge sys_clk) begin
		state <= next_state;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Outputs

	assign rd_data    = state.rd_data;
	assign rd_done    = state.rd_done;
	assign acc_done   = state.acc_done;
	assign halted     = state.halted;
	assign wake_pulse = state.wake_pulse;
	assign pin_a_out  = state.pout[0];
	assign pin_b_out  = state.pout[1];
	assign pin_c_out  = state.pout[2];
	assign pin_d_out  = state.pout[3];
	assign pin_a_oe_n = state.poe_n[0];
	assign pin_b_oe_n = state.poe_n[1];
	assign pin_c_oe_n = state.poe_n[2];
	assign pin_d_oe_n = state.poe_n[3];
	assign pull_a     = state.pull[0];
	assign pull_b     = state.pull[1];
	assign pull_c     = state.pull[2];
	assign pull_d     = state.pull[3];
endmodule

// ---- design/io_port_pkg.sv ----
// Purpose: Constants and types for the four-port I/O block with wake-up
// Assumes: Ports are eight bits wide; one clock, synchronous reset
// Notes:   Parameter defaults below are the documented values
// Notes on behaviour
// - In power-down stay idle until an enabled port A pin falls, then wake.
// - Each port A pin has its own wake-up enable bit.
// - Each pin maps to the same bit of its own port's direction register.
// - Direction bit 1 makes the pin an input; data reads return pin level.
// - Direction bit 0 drives the pin from its data latch.
// - Reading an output pin returns the latch, not the pin.
// - Divider output drives its pin only if option chosen and direction output.
// - Each PWM output drives its pin only if option chosen and direction output.
// - Divider and PWM pin options are fixed straps, not changeable at run time.
// - Pull-high is removed from port B pins assigned to analog input.
// - After reset all data and direction registers are all ones.
// - Bit set or clear reads the whole port, changes one bit, writes back.
// - Inputs are not latched; sampled at the read instruction's T2 edge.
// - Output latch holds its value until software writes it again.
package io_port_pkg;
	localparam int           PORT_W      = 8;
	localparam int           NUM_PORTS   = 4;
	localparam int           ANALOG_W    = 4;
	localparam logic [7:0]   RESET_BYTE  = 8'hFF;
	localparam logic [1:0]   PORT_A      = 2'h0;
	localparam logic [1:0]   PORT_B      = 2'h1;
	localparam logic [1:0]   PORT_C      = 2'h2;
	localparam logic [1:0]   PORT_D      = 2'h3;
	localparam int           DIV_BIT     = 3;
	localparam int           PWM0_BIT    = 0;
	localparam int           PWM1_BIT    = 1;
	localparam int           ANALOG_LSB  = 0;

	typedef enum logic [1:0] {
		OP_WRITE_BYTE,
		OP_SET_BIT,
		OP_CLEAR_BIT,
		OP_NONE
	} op_t;

	typedef enum logic {
		SEL_DATA,
		SEL_DIRECTION
	} target_t;
endpackage

// ---- design/port_bank.sv ----
// Purpose: Small register bank holding the data latches and direction bytes
// Assumes: One write port, one registered read port
// Notes:   Reset loads all ones into every entry
`timescale 1ns/1ps
module port_bank #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input  wire logic                     sys_clk,
	input  wire logic                     nrst,
	input  wire logic                     wr_en,
	input  wire logic [$clog2(DEPTH)-1:0] wr_addr,
	input  wire logic [WIDTH-1:0]         wr_data,
	input  wire logic [$clog2(DEPTH)-1:0] rd_addr,
	output logic      [WIDTH-1:0]         rd_data,
	output logic      [DEPTH*WIDTH-1:0]   all_data
);
	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [WIDTH-1:0]            rd;
	} bank_state_t;

	bank_state_t state;
	bank_state_t next_state;

	always_comb begin
		next_state = state;
		if (wr_en) begin
			next_state.mem[wr_addr] = wr_data;
		end
		next_state.rd = state.mem[rd_addr];
		if (!nrst) begin
			for (int i = 0; i < DEPTH; i++) begin
				next_state.mem[i] = {WIDTH{1'b1}};
			end
			next_state.rd = {WIDTH{1'b1}};
		end
	end

	always_ff @(posedge sys_clk) begin
		state <= next_state;
	end

	assign rd_data  = state.rd;
	assign all_data = state.mem;
endmodule

// ---- sim/io_pin_model.sv ----
// Purpose: Board circuitry on one eight-pin port
// Assumes: Pad driver wins over the external source
// Notes: No timer or interrupt traffic; the bench drives the divider and PWM0 shared pins
`timescale 1ns/1ps
module io_pin_model (
	input wire logic       sys_clk,
	input wire logic [7:0] pad_out,
	input wire logic [7:0] pad_oe_n,
	input wire logic [7:0] pad_pull,
	input wire logic [7:0] ext_en,
	input wire logic [7:0] ext_val,
	output logic     [7:0] level
);
	logic [7:0] last = 8'h00;
	always_ff @(posedge sys_clk) begin
		last <= level;
	end
	// Floating pins wander, so unbonded inputs need a pull
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			level[i] = !pad_oe_n[i] ? pad_out[i] : ext_en[i] ? ext_val[i] : pad_pull[i] | ~last[i];
		end
	end
endmodule

// ---- sim/io_port_block_sva.sv ----
// Purpose: Port-level properties of the four-port I/O block
// Assumes: One clock, synchronous active-low reset
// Notes:   Sees only the top module's ports
`timescale 1ns/1ps
module io_port_block_sva #(
	parameter int WIDTH = 8
) (
	input wire logic             sys_clk,
	input wire logic             nrst,
	input wire logic             acc_valid,
	input wire logic [1:0]       acc_op,
	input wire logic             acc_done,
	input wire logic             rd_valid,
	input wire logic             rd_done,
	input wire logic             halt_req,
	input wire logic [WIDTH-1:0] wake_enable,
	input wire logic             halted,
	input wire logic             wake_pulse,
	input wire logic [WIDTH-1:0] pin_a_in,
	input wire logic [3:0]       analog_select,
	input wire logic [WIDTH-1:0] pull_b,
	input wire logic [WIDTH-1:0] pull_d,
	input wire logic [WIDTH-1:0] pin_d_oe_n,
	input wire logic [WIDTH-1:0] pin_c_out,
	input wire logic [WIDTH-1:0] pin_c_oe_n
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!nrst);
	////////////////////////////////////////////////////////////////////////
	property p_halt_entry; halt_req && !halted |=> halted; endproperty
	a_halt_entry: assert property (p_halt_entry)
		else $error("halt request did not enter power-down");
	property p_stay_idle;
		halted && ((wake_enable & $past(pin_a_in) & ~pin_a_in) == '0) |=> halted && !wake_pulse;
	endproperty
	a_stay_idle: assert property (p_stay_idle)
		else $error("left power-down without an enabled falling pin");
	property p_wake;
		halted && ((wake_enable & $past(pin_a_in) & ~pin_a_in) != '0) |=> !halted && wake_pulse;
	endproperty
	a_wake: assert property (p_wake)
		else $error("enabled falling pin did not wake");
	property p_pulse_once; wake_pulse |=> !wake_pulse; endproperty
	a_pulse_once: assert property (p_pulse_once)
		else $error("wake pulse longer than one cycle");
	property p_byte_done; acc_valid && acc_op == 2'h0 |=> acc_done; endproperty
	a_byte_done: assert property (p_byte_done)
		else $error("byte write not committed next cycle");
	property p_rmw_done;
		acc_valid && acc_op inside {2'h1, 2'h2} |=> !acc_done ##1 acc_done;
	endproperty
	a_rmw_done: assert property (p_rmw_done)
		else $error("bit write did not take two cycles");
	property p_read_done; rd_valid |-> ##2 rd_done; endproperty
	a_read_done: assert property (p_read_done)
		else $error("read result late or missing");
	property p_analog_pull; (pull_b[3:0] & $past(analog_select)) == 4'h0; endproperty
	a_analog_pull: assert property (p_analog_pull)
		else $error("pull-high kept on an analog pin");
	property p_pull_input; (pull_d & ~pin_d_oe_n) == '0; endproperty
	a_pull_input: assert property (p_pull_input)
		else $error("pull-high on a driven pin");
	property p_latch_hold; !acc_done |=> $stable({pin_c_out, pin_c_oe_n}); endproperty
	a_latch_hold: assert property (p_latch_hold)
		else $error("port pads changed without a write");
	c_wake: cover property (halted ##1 wake_pulse);
	c_rmw: cover property (acc_valid && acc_op == 2'h1);
	c_read: cover property (rd_done);
endmodule
bind io_port_block io_port_block_sva #(.WIDTH(WIDTH)) chk (.*);

// ---- sim/io_port_block_test.sv ----
// Purpose: Self-checking bench for the four-port I/O block
// Assumes: Straps fixed from time zero
// Notes:   Port C carries an external pattern, port A the wake switches
`timescale 1ns/1ps
module io_port_block_test;
	logic       sys_clk = 0, nrst = 0, acc_valid = 0, acc_target = 0, rd_valid = 0;
	logic       rd_target = 0, halt_req = 0, rd_done, acc_done, halted, wake_pulse;
	logic       opt_divider_en = 1, opt_pwm0_en = 1, opt_pwm1_en = 0;
	logic       freq_divider_output = 0, pwm0_out = 0, pwm1_out = 0;
	logic [1:0] acc_port = 0, acc_op = 0, rd_port = 0;
	logic [2:0] acc_bit = 0;
	logic [3:0] analog_select = 0;
	logic [7:0] acc_wdata = 0, wake_enable = 0, rd_data;
	logic [7:0] opt_pull_high_a = 8'hFF, opt_pull_high_b = 8'hFF;
	logic [7:0] opt_pull_high_c = 8'h00, opt_pull_high_d = 8'hFF;
	logic [7:0] pin_a_in, pin_b_in, pin_c_in, pin_d_in, pin_a_out, pin_b_out, pin_c_out;
	logic [7:0] pin_d_out, pin_a_oe_n, pin_b_oe_n, pin_c_oe_n, pin_d_oe_n;
	logic [7:0] pull_a, pull_b, pull_c, pull_d;
	logic [7:0] ext_en [4] = '{8'h00, 8'h00, 8'hFF, 8'h00};
	logic [7:0] ext_val [4] = '{8'h00, 8'h00, 8'h5A, 8'h00};
	int         n_mismatch = 0, checked = 0;
	always #10 sys_clk = ~sys_clk;
	io_port_block dut (.*);
	io_pin_model pm_a (.sys_clk, .pad_out(pin_a_out), .pad_oe_n(pin_a_oe_n), .pad_pull(pull_a),
		.ext_en(ext_en[0]), .ext_val(ext_val[0]), .level(pin_a_in));
	io_pin_model pm_b (.sys_clk, .pad_out(pin_b_out), .pad_oe_n(pin_b_oe_n), .pad_pull(pull_b),
		.ext_en(ext_en[1]), .ext_val(ext_val[1]), .level(pin_b_in));
	io_pin_model pm_c (.sys_clk, .pad_out(pin_c_out), .pad_oe_n(pin_c_oe_n), .pad_pull(pull_c),
		.ext_en(ext_en[2]), .ext_val(ext_val[2]), .level(pin_c_in));
	io_pin_model pm_d (.sys_clk, .pad_out(pin_d_out), .pad_oe_n(pin_d_oe_n), .pad_pull(pull_d),
		.ext_en(ext_en[3]), .ext_val(ext_val[3]), .level(pin_d_in));
	////////////////////////////////////////////////////////////////////////////
	task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		checked++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic idle(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask
	// Done flag may already be up one step after the taking edge
	task automatic wr(input logic [1:0] p, input logic t, input logic [1:0] op,
			input logic [2:0] b, input logic [7:0] d);
		int n;
		@(posedge sys_clk);
		acc_valid <= 1'b1;
		acc_port <= p;
		acc_target <= t;
		acc_op <= op;
		acc_bit <= b;
		acc_wdata <= d;
		@(posedge sys_clk);
		acc_valid <= 1'b0;
		#1;
		n = 0;
		while (acc_done !== 1'b1 && n < 4) begin
			idle(1);
			n++;
		end
		chk("acc_done", {7'h00, acc_done}, 8'h01);
	endtask
	task automatic rd(input logic [1:0] p, input logic t, input logic [7:0] exp, input string nm);
		int n;
		@(posedge sys_clk);
		rd_valid <= 1'b1;
		rd_port <= p;
		rd_target <= t;
		@(posedge sys_clk);
		rd_valid <= 1'b0;
		#1;
		n = 0;
		while (rd_done !== 1'b1 && n < 4) begin
			idle(1);
			n++;
		end
		chk(nm, rd_data, exp);
	endtask
	task automatic end_of_test;
		$display("checked %0d n_mismatch %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////
	initial begin
		idle(2000);
		n_mismatch++;
		end_of_test;
	end
	initial begin
		int n;
		repeat (5) @(posedge sys_clk);
		nrst <= 1'b1;
		for (int p = 0; p < 4; p++) begin
			rd(p[1:0], 1'b1, 8'hFF, "direction");
			rd(p[1:0], 1'b0, (p == 2) ? 8'h5A : 8'hFF, "data");
		end
		chk("pull_b", pull_b, 8'hFF);
		chk("pull_c", pull_c, 8'h00);
		@(posedge sys_clk);
		analog_select <= 4'h5;
		idle(2);
		chk("pull_b", pull_b, 8'hFA);
		wr(2'h1, 1'b1, 2'h0, 3'h0, 8'h00);
		idle(2);
		chk("pin_b_oe_n", pin_b_oe_n, 8'h00);
		chk("pin_b_out", pin_b_out, 8'hFF);
		wr(2'h2, 1'b1, 2'h0, 3'h0, 8'h0F);
		rd(2'h2, 1'b1, 8'h0F, "direction");
		wr(2'h2, 1'b0, 2'h0, 3'h0, 8'hC3);
		rd(2'h2, 1'b0, 8'hCA, "data");
		chk("pin_c_out", pin_c_out, 8'hC3);
		chk("pin_c_oe_n", pin_c_oe_n, 8'h0F);
		// Bit writes copy the input pins into the latch
		wr(2'h2, 1'b0, 2'h1, 3'h5, 8'h00);
		wr(2'h2, 1'b0, 2'h2, 3'h3, 8'h00);
		wr(2'h2, 1'b1, 2'h0, 3'h0, 8'h00);
		rd(2'h2, 1'b0, 8'hE2, "data");
		chk("pin_c_out", pin_c_out, 8'hE2);
		wr(2'h2, 1'b1, 2'h1, 3'h4, 8'h00);
		wr(2'h2, 1'b1, 2'h2, 3'h0, 8'h00);
		rd(2'h2, 1'b1, 8'h10, "direction");
		chk("pull_a", pull_a, 8'hFF);
		wr(2'h0, 1'b1, 2'h0, 3'h0, 8'hF7);
		idle(2);
		chk("pin_a_oe_n", pin_a_oe_n, 8'hF7);
		chk("pin_a_out", pin_a_out, 8'hF7);
		chk("pull_a", pull_a, 8'hF7);
		@(posedge sys_clk);
		freq_divider_output <= 1'b1;
		idle(3);
		chk("pin_a_out", pin_a_out, 8'hFF);
		wr(2'h3, 1'b1, 2'h0, 3'h0, 8'hFC);
		idle(2);
		chk("pin_d_out", pin_d_out, 8'hFE);
		chk("pin_d_oe_n", pin_d_oe_n, 8'hFC);
		chk("pull_d", pull_d, 8'hFC);
		@(posedge sys_clk);
		pwm0_out <= 1'b1;
		idle(3);
		chk("pin_d_out", pin_d_out, 8'hFF);
		@(posedge sys_clk);
		wake_enable <= 8'h02;
		halt_req <= 1'b1;
		@(posedge sys_clk);
		halt_req <= 1'b0;
		idle(1);
		chk("halted", {7'h00, halted}, 8'h01);
		@(posedge sys_clk);
		ext_en[0] <= 8'h01;
		idle(4);
		chk("halted", {7'h00, halted}, 8'h01);
		@(posedge sys_clk);
		ext_en[0] <= 8'h03;
		n = 0;
		do begin
			idle(1);
			n++;
		end while (wake_pulse !== 1'b1 && n < 4);
		chk("wake_pulse", {7'h00, wake_pulse}, 8'h01);
		idle(1);
		chk("halted", {7'h00, halted}, 8'h00);
		@(posedge sys_clk);
		nrst <= 1'b0;
		idle(2);
		@(posedge sys_clk);
		nrst <= 1'b1;
		rd(2'h2, 1'b1, 8'hFF, "direction");
		chk("pin_c_out", pin_c_out, 8'hFF);
		end_of_test;
	end
endmodule
